// ### lar_consts.svh
/*
  Constants of the line autoreclose sequencer: clock figures, register
  offsets, field positions, reset values and input slot numbers.
  Assumes it is included by bare name; it holds definitions only.
*/
`ifndef LAR_CONSTS_SVH
`define LAR_CONSTS_SVH
// Clock rate in kHz and timer figures in ms
`define LAR_CLK_KHZ 100000
`define LAR_TICK_MS 10
`define LAR_FORCE_MS 8
// Register byte offsets
`define LAR_OFF_CTRL 6'h00
`define LAR_OFF_TM0 6'h04
`define LAR_OFF_STAT 6'h1c
// Timer setting slots, in offset order from TM0
`define LAR_T_SP 3'h0
`define LAR_T_A 3'h1
`define LAR_T_B 3'h2
`define LAR_T_RST 3'h3
`define LAR_T_INC 3'h4
`define LAR_T_XFER 3'h5
`define LAR_T_NUM 6
// Control fields
`define LAR_CTRL_EN 0
`define LAR_CTRL_PROG 1
`define LAR_CTRL_MAX 3
`define LAR_CTRL_ORD 4
`define LAR_CTRL_ARM 6
`define LAR_CTRL_W 6
`define LAR_CTRL_RST 6'h08
// Timer reset values in 10 ms ticks
`define LAR_SP_RST 16'h0064
`define LAR_A_RST 16'h0032
`define LAR_B_RST 16'h0078
`define LAR_RT_RST 16'h1770
`define LAR_INC_RST 16'h03e8
`define LAR_XFER_RST 16'h0064
// Synchronised input slots
`define LAR_IN_SP 0
`define LAR_IN_TP 1
`define LAR_IN_TD 2
`define LAR_IN_HOLD 3
`define LAR_IN_RST 4
`define LAR_IN_B1 5
`define LAR_IN_B2 6
`define LAR_IN_W 7
`endif

// ### lar_pkg.sv
/*
  Types of the line autoreclose sequencer: scheme states, dead timer
  choices and breaker orders.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lar_pkg;
  // Scheme states
  typedef enum logic [2:0] {
    lar_st_disabled, lar_st_reset, lar_st_rip, lar_st_closing, lar_st_lockout
  } lar_state_t;
  // Dead timer chosen for a shot
  typedef enum logic [1:0] {lar_dt_sp, lar_dt_a, lar_dt_b, lar_dt_lock} lar_dead_t;
  // Breaker close order
  typedef enum logic [1:0] {
    lar_ord_single, lar_ord_both, lar_ord_seq12, lar_ord_seq21
  } lar_order_t;
endpackage

// ### lar_tick_div.sv
/*
  Divider that makes the 10 ms timer tick as a one-cycle enable.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module lar_tick_div #(
  parameter int unsigned DIV = 1000000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sync_clear,
  output logic tick
);
  localparam int unsigned W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_q; // Cycles within the current tick period

  ////////////////////////////////////////////////////////////////////
  // Free counter, restarted by the scheme clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (sync_clear) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      // Pulse in the cycle after the last cycle of each period
      tick <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end
endmodule

// ### lar_sequencer.sv
/*
  Line autoreclose sequencer: scheme state machine, dead, incomplete,
  reset and transfer timers, close latches and an Avalon-MM slave for
  the settings.
  Assumes the initiate, hold, reset and breaker inputs are asynchronous
  levels and that the trip logic honours the force-three-pole output.
*/
// Design decisions made here: register access over Avalon-MM and the register offsets.
// Notes on behaviour
// - Disabled ignores initiates; reset clears shot count
// - Four reclose programs selected by setting
// - Maximum shots one or two, default two
// - Second shot three-pole with own dead time
// - Program 1: single, A, or B timer
// - Program 2: single-pole timer, three-phase locks out
// - Program 3: single-phase uses A, multi locks
// - Program 4: timer A, delayed initiate timer B
// - Programs 3 and 4 force three-pole trip
// - At shot limit, further initiate locks out
// - Initiate latches in-progress until close or lockout
// - Dead time expiry latches close per order
// - Three initiate kinds each start a cycle
// - Three-pole initiates latched until close, lockout, reset
// - Times settable 0 to 655.35 s, 10 ms steps
// - Close one breaker, both, or in turn
// - Lockout holds until explicit reset
// - Hold freezes dead timers, then timer B
// - Force three-pole 8 ms after single-pole start
// - Incomplete timer expiry without close locks out
// - Reset timer after close returns to reset
`timescale 1ns/1ps
`include "lar_consts.svh"
module lar_sequencer import lar_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `LAR_TICK_MS * `LAR_CLK_KHZ,
  parameter int unsigned FORCE_CYCLES = `LAR_FORCE_MS * `LAR_CLK_KHZ
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sync_clear,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic single_pole_initiate,
  input wire logic three_pole_initiate,
  input wire logic delayed_three_pole_initiate,
  input wire logic hold_input,
  input wire logic scheme_reset_input,
  input wire logic breaker_one_closed,
  input wire logic breaker_two_closed,
  output logic reclose_in_progress_flag,
  output logic close_breaker_one,
  output logic close_breaker_two,
  output logic force_three_pole_trip,
  output logic lockout_flag
);
  localparam int unsigned FW = $clog2(FORCE_CYCLES);
  localparam logic [FW-1:0] FLAST = FW'(FORCE_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic [`LAR_IN_W-1:0] pins_in, s1_q, s2_q, prev_q; // Input synchroniser
  logic sp_i, tp_i, td_i, hold_i, rst_i, b1_i, b2_i; // Synchronised levels
  logic [`LAR_CTRL_W-1:0] ctrl_q; // Control settings
  logic [15:0] tm_q [`LAR_T_NUM]; // Timer settings in ticks
  logic ack_q, arm_sw_q; // Bus answer, software arm pulse
  logic [31:0] rdata_q; // Read data
  lar_state_t st_q; // Scheme state
  lar_dead_t sel, dsel_q; // Chosen and running dead timer
  logic [1:0] shot_q; // Recloses issued this sequence
  logic rip_q, cls1_q, cls2_q, lock_q, force_q;
  logic tp_lat_q, td_lat_q; // Latched three-pole initiates
  logic frun_q, fsp_q; // Force delay running and done
  logic [FW-1:0] fcnt_q; // Force delay count in cycles
  logic xfer_q; // Transfer to second breaker pending
  logic [15:0] dead_cnt_q, inc_cnt_q, rst_cnt_q, xfer_cnt_q;
  logic tick, en, init_rise, tp_any, td_any, init_present, at_max, armed;
  logic new_init, start_cycle, dead_done, inc_done, do_close, rst_done;
  logic closed_ok, arm_req, to_lock, to_reset, xfer_done, hold_fall;
  logic [1:0] prog, max_shots;
  lar_order_t order;

  ////////////////////////////////////////////////////////////////////
  // Functions
  // Dead timer per program, fault kind and shot
  function automatic lar_dead_t dead_sel(input logic [1:0] p, input logic sp,
      input logic tp, input logic td, input logic later);
    lar_dead_t r;
    r = lar_dt_lock;
    if (later) begin
      // Later shots on timer B, except program 3 locks out on a three-pole initiate
      r = (p == 2'h2 && (tp || td)) ? lar_dt_lock : lar_dt_b;
    end else begin
      unique case (p)
        2'h0: r = td ? lar_dt_b : (tp ? lar_dt_a : lar_dt_sp);
        2'h1: r = (tp || td) ? lar_dt_lock : lar_dt_sp;
        2'h2: r = (tp || td) ? lar_dt_lock : lar_dt_a;
        2'h3: r = td ? lar_dt_b : lar_dt_a;
      endcase
    end
    return r;
  endfunction

  // Byte-lane merge of a 16-bit setting
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) r[7:0] = wd[7:0];
    if (be[1]) r[15:8] = wd[15:8];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Tick divider
  lar_tick_div #(.DIV(TICK_CYCLES)) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .sync_clear(sync_clear),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////
  // Input synchroniser; logic reads only the second stage and after
  assign pins_in = {breaker_two_closed, breaker_one_closed, scheme_reset_input,
      hold_input, delayed_three_pole_initiate, three_pole_initiate,
      single_pole_initiate};
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      prev_q <= '0;
    end else begin
      s1_q <= pins_in;
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end
  assign sp_i = s2_q[`LAR_IN_SP];
  assign tp_i = s2_q[`LAR_IN_TP];
  assign td_i = s2_q[`LAR_IN_TD];
  assign hold_i = s2_q[`LAR_IN_HOLD];
  assign rst_i = s2_q[`LAR_IN_RST];
  assign b1_i = s2_q[`LAR_IN_B1];
  assign b2_i = s2_q[`LAR_IN_B2];

  ////////////////////////////////////////////////////////////////////
  // Sequencing decisions
  assign en = ctrl_q[`LAR_CTRL_EN];
  assign prog = ctrl_q[`LAR_CTRL_PROG +: 2];
  assign max_shots = ctrl_q[`LAR_CTRL_MAX] ? 2'h2 : 2'h1;
  assign order = lar_order_t'(ctrl_q[`LAR_CTRL_ORD +: 2]);
  // Any of the three initiates rising starts a cycle
  assign init_rise = |(s2_q[`LAR_IN_TD:`LAR_IN_SP] & ~prev_q[`LAR_IN_TD:`LAR_IN_SP]);
  assign tp_any = tp_i | tp_lat_q;
  assign td_any = td_i | td_lat_q;
  assign init_present = sp_i | tp_any | td_any;
  assign hold_fall = prev_q[`LAR_IN_HOLD] & ~hold_i;
  assign at_max = (shot_q >= max_shots);
  assign sel = dead_sel(prog, sp_i, tp_any, td_any, shot_q != 2'h0);
  assign armed = (st_q == lar_st_reset) || (st_q == lar_st_closing);
  assign new_init = en & armed & init_rise;
  // Shot limit or a locking program refuses the cycle
  assign start_cycle = new_init & ~at_max & (sel != lar_dt_lock);
  assign dead_done = (dead_cnt_q >= tm_q[dsel_q]);
  assign inc_done = (st_q == lar_st_rip) && (inc_cnt_q >= tm_q[`LAR_T_INC]);
  // Incomplete expiry wins over a close in the same cycle
  assign do_close = (st_q == lar_st_rip) && dead_done && !hold_i && !inc_done;
  assign rst_done = (st_q == lar_st_closing) && (rst_cnt_q >= tm_q[`LAR_T_RST]);
  assign closed_ok = (order == lar_ord_single) ? b1_i : (b1_i & b2_i);
  assign arm_req = rst_i | arm_sw_q;
  assign xfer_done = xfer_q && (xfer_cnt_q >= tm_q[`LAR_T_XFER]);
  assign to_lock = en & ((new_init & ~start_cycle) | inc_done
      | (rst_done & ~new_init & ~(closed_ok & ~init_present)));
  assign to_reset = en & ((rst_done & ~new_init & closed_ok & ~init_present)
      | ((st_q == lar_st_lockout) & arm_req) | (st_q == lar_st_disabled));

  ////////////////////////////////////////////////////////////////////
  // Scheme state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= lar_st_disabled;
    end else if (sync_clear || !en) begin
      st_q <= lar_st_disabled;
    end else if (to_lock) begin
      st_q <= lar_st_lockout;
    end else if (start_cycle) begin
      st_q <= lar_st_rip;
    end else if (do_close) begin
      st_q <= lar_st_closing;
    end else if (to_reset) begin
      st_q <= lar_st_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Shot counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shot_q <= 2'h0;
    end else if (sync_clear || !en || to_reset) begin
      shot_q <= 2'h0;
    end else if (do_close) begin
      shot_q <= shot_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Dead timer: chosen at initiate, frozen by hold, B after hold
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dsel_q <= lar_dt_sp;
      dead_cnt_q <= 16'h0000;
    end else if (sync_clear) begin
      dsel_q <= lar_dt_sp;
      dead_cnt_q <= 16'h0000;
    end else if (start_cycle) begin
      dsel_q <= sel;
      dead_cnt_q <= 16'h0000;
    end else if (st_q == lar_st_rip && hold_fall) begin
      dsel_q <= lar_dt_b;
      dead_cnt_q <= 16'h0000;
    end else if (st_q == lar_st_rip && tick && !hold_i && !dead_done) begin
      dead_cnt_q <= dead_cnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Incomplete sequence timer, runs while in progress
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      inc_cnt_q <= 16'h0000;
    end else if (sync_clear || start_cycle) begin
      inc_cnt_q <= 16'h0000;
    end else if (st_q == lar_st_rip && tick && !inc_done) begin
      inc_cnt_q <= inc_cnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reset timer, started by the close command
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_q <= 16'h0000;
    end else if (sync_clear || do_close) begin
      rst_cnt_q <= 16'h0000;
    end else if (st_q == lar_st_closing && tick && !rst_done) begin
      rst_cnt_q <= rst_cnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transfer timer for closing breakers in turn; initiate stops it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      xfer_q <= 1'b0;
      xfer_cnt_q <= 16'h0000;
    end else if (sync_clear || !en || start_cycle || to_lock || xfer_done) begin
      xfer_q <= 1'b0;
      xfer_cnt_q <= 16'h0000;
    end else if (do_close) begin
      xfer_q <= (order == lar_ord_seq12) || (order == lar_ord_seq21);
      xfer_cnt_q <= 16'h0000;
    end else if (xfer_q && tick) begin
      xfer_cnt_q <= xfer_cnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Close latches; a set wins over a breaker-closed clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cls1_q <= 1'b0;
      cls2_q <= 1'b0;
    end else if (sync_clear || !en || to_lock || to_reset) begin
      cls1_q <= 1'b0;
      cls2_q <= 1'b0;
    end else begin
      // Breaker one first unless order starts with two
      if ((do_close && order != lar_ord_seq21)
          || (xfer_done && order == lar_ord_seq21)) begin
        cls1_q <= 1'b1;
      end else if (b1_i) begin
        cls1_q <= 1'b0;
      end
      // Breaker two together, first, or after transfer
      if ((do_close && (order == lar_ord_both || order == lar_ord_seq21))
          || (xfer_done && order == lar_ord_seq12)) begin
        cls2_q <= 1'b1;
      end else if (b2_i) begin
        cls2_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // In-progress and lockout indications
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rip_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (sync_clear || !en) begin
      rip_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      // Latched until close or lockout
      if (start_cycle) rip_q <= 1'b1;
      else if (do_close || to_lock) rip_q <= 1'b0;
      if (to_lock) lock_q <= 1'b1;
      else if (to_reset) lock_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Three-pole initiate latches; a live initiate wins over the clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tp_lat_q <= 1'b0;
      td_lat_q <= 1'b0;
    end else if (sync_clear || !en) begin
      tp_lat_q <= 1'b0;
      td_lat_q <= 1'b0;
    end else begin
      if (tp_i && st_q != lar_st_lockout) tp_lat_q <= 1'b1;
      else if (do_close || xfer_done || to_lock || to_reset) tp_lat_q <= 1'b0;
      if (td_i && st_q != lar_st_lockout) td_lat_q <= 1'b1;
      else if (do_close || xfer_done || to_lock || to_reset) td_lat_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Force three-pole: programs 3 and 4, later shots, or 8 ms delay
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frun_q <= 1'b0;
      fsp_q <= 1'b0;
      fcnt_q <= '0;
    end else if (sync_clear || !en || to_lock || to_reset) begin
      frun_q <= 1'b0;
      fsp_q <= 1'b0;
      fcnt_q <= '0;
    end else if (start_cycle && sel == lar_dt_sp) begin
      frun_q <= 1'b1;
      fcnt_q <= '0;
    end else if (frun_q) begin
      // Cycle count, finer than the tick
      fcnt_q <= fcnt_q + 1'b1;
      if (fcnt_q == FLAST) begin
        frun_q <= 1'b0;
        fsp_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      force_q <= 1'b0;
    end else begin
      force_q <= !sync_clear && en && (prog[1] || fsp_q || shot_q != 2'h0);
    end
  end

  assign reclose_in_progress_flag = rip_q;
  assign close_breaker_one = cls1_q;
  assign close_breaker_two = cls2_q;
  assign force_three_pole_trip = force_q;
  assign lockout_flag = lock_q;

  ////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rdata_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (avs_read && !ack_q) begin
        // Unmapped addresses read as zero
        rdata_q <= 32'h0000_0000;
        if (avs_address == `LAR_OFF_CTRL) begin
          rdata_q[`LAR_CTRL_W-1:0] <= ctrl_q;
        end else if (avs_address == `LAR_OFF_STAT) begin
          rdata_q[9:0] <= {st_q, shot_q, rip_q, cls1_q, cls2_q, lock_q, force_q};
        end else if (avs_address >= `LAR_OFF_TM0 && avs_address < `LAR_OFF_STAT
            && avs_address[1:0] == 2'h0) begin
          rdata_q[15:0] <= tm_q[avs_address[4:2] - 3'h1];
        end
      end
    end
  end

  // Settings writes take effect at the answering edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `LAR_CTRL_RST;
      arm_sw_q <= 1'b0;
      tm_q[`LAR_T_SP] <= `LAR_SP_RST;
      tm_q[`LAR_T_A] <= `LAR_A_RST;
      tm_q[`LAR_T_B] <= `LAR_B_RST;
      tm_q[`LAR_T_RST] <= `LAR_RT_RST;
      tm_q[`LAR_T_INC] <= `LAR_INC_RST;
      tm_q[`LAR_T_XFER] <= `LAR_XFER_RST;
    end else begin
      arm_sw_q <= 1'b0;
      if (avs_write && ack_q) begin
        if (avs_address == `LAR_OFF_CTRL && avs_byteenable[0]) begin
          ctrl_q <= avs_writedata[`LAR_CTRL_W-1:0];
          arm_sw_q <= avs_writedata[`LAR_CTRL_ARM];
        end else if (avs_address >= `LAR_OFF_TM0 && avs_address < `LAR_OFF_STAT
            && avs_address[1:0] == 2'h0) begin
          // Full 16-bit range of 10 ms steps
          tm_q[avs_address[4:2] - 3'h1] <= merge16(tm_q[avs_address[4:2] - 3'h1],
              avs_writedata, avs_byteenable);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n || sync_clear);

  property p_off;
    !en |=> st_q == lar_st_disabled && !rip_q && !cls1_q && !cls2_q;
  endproperty
  a_off: assert property (p_off) else $error("scheme active while off");
  property p_zero;
    st_q == lar_st_reset |-> shot_q == 2'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("shot count not zero in reset");
  property p_max;
    (new_init && at_max) ##1 en |-> st_q == lar_st_lockout && lock_q;
  endproperty
  a_max: assert property (p_max) else $error("initiate at limit not locked");
  property p_prog2;
    (new_init && prog == 2'h1 && tp_any && shot_q == 2'h0) ##1 en
      |-> st_q == lar_st_lockout;
  endproperty
  a_prog2: assert property (p_prog2) else $error("three-phase fault reclosed");
  property p_sel1;
    (start_cycle && prog == 2'h0 && !tp_any && !td_any && shot_q == 2'h0)
      |=> dsel_q == lar_dt_sp;
  endproperty
  a_sel1: assert property (p_sel1) else $error("wrong first-shot timer");
  property p_force;
    en && prog[1] |=> force_three_pole_trip;
  endproperty
  a_force: assert property (p_force) else $error("force missing");
  property p_rip;
    start_cycle ##1 en |-> reclose_in_progress_flag && st_q == lar_st_rip;
  endproperty
  a_rip: assert property (p_rip) else $error("in-progress not set");
  property p_both;
    (do_close && order == lar_ord_both) ##1 en |-> cls1_q && cls2_q;
  endproperty
  a_both: assert property (p_both) else $error("both closes not issued");
  property p_lock;
    (st_q == lar_st_lockout && !arm_req) ##1 en |-> st_q == lar_st_lockout;
  endproperty
  a_lock: assert property (p_lock) else $error("lockout left without reset");
  property p_hold;
    st_q == lar_st_rip && hold_i |=> $stable(dead_cnt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("dead timer ran in hold");
  property p_inc;
    inc_done ##1 en |-> st_q == lar_st_lockout && !rip_q;
  endproperty
  a_inc: assert property (p_inc) else $error("incomplete expiry not locked");

  c_cycle: cover property (start_cycle);
  c_close: cover property (do_close ##[1:1000] rst_done);
  c_lock: cover property (to_lock);
  c_xfer: cover property (xfer_done);
endmodule

// ### lar_brk_model.sv
/* Far-side breaker model for the autoreclose bench.
   Assumes one clock and a latched close command from the sequencer. */
`timescale 1ns/1ps
module lar_brk_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic close_cmd,
  input wire logic trip,
  output logic closed
);
  logic [2:0] dly_q; // Mechanism travel time
  // Trip opens at once; a close takes a few cycles, so the latch is seen
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dly_q <= 3'h0;
      closed <= 1'b1;
    end else if (trip) begin
      closed <= 1'b0;
      dly_q <= 3'h0;
    end else if (close_cmd && !closed) begin
      dly_q <= dly_q + 3'h1;
      closed <= (dly_q == 3'h4);
    end
  end
endmodule

// ### tb_top.sv
/* Self-checking bench of the autoreclose sequencer.
   Assumes lar_sequencer, its package and the breaker model. */
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'h0, rst_n = 1'h0, sync_clear = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic hold_input = 1'h0, scheme_reset_input = 1'h0, trip = 1'h0, avs_waitrequest;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, rs = 32'h00009bed;
  logic [3:0] avs_byteenable = 4'h3;
  logic [2:0] ini = 3'h0; // Delayed, three-pole, single-pole
  wire single_pole_initiate = ini[0];
  wire three_pole_initiate = ini[1];
  wire delayed_three_pole_initiate = ini[2];
  logic breaker_one_closed, breaker_two_closed, reclose_in_progress_flag;
  logic close_breaker_one, close_breaker_two, force_three_pole_trip, lockout_flag;
  int fails = 0, num_checks = 0, cyc = 0, n, p, k, t, sp;
  lar_sequencer #(.TICK_CYCLES(10), .FORCE_CYCLES(8)) dut (.*);
  lar_brk_model b1 (.clock, .rst_n, .close_cmd(close_breaker_one), .trip,
    .closed(breaker_one_closed));
  lar_brk_model b2 (.clock, .rst_n, .close_cmd(close_breaker_two), .trip,
    .closed(breaker_two_closed));
  always #5 clock = ~clock;
  // Hang guard
  always @(posedge clock) if (++cyc == 30000) begin
    fails++;
    complete_run();
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // Dead ticks per program and initiate kind; zero means lockout
  function automatic int dt(int p, int k, int sp);
    if ((p == 1 || p == 2) && k != 1) return 0;
    if (p == 1 || (p == 0 && k == 1)) return sp;
    return (k == 4 && p != 2) ? 15 : 9;
  endfunction
  task automatic complete_run();
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Avalon master: hold request until waitrequest seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic stat(input string nm, input logic [2:0] e);
    bus(1'b0, 6'h1c, 32'h0);
    chk(nm, q[9:7], e);
  endtask
  // Trip and initiate together, as protection would
  task automatic pulse(input logic [2:0] kd);
    @(posedge clock);
    ini <= kd;
    trip <= 1'b1;
    repeat (5) @(posedge clock);
    ini <= 3'h0;
    trip <= 1'b0;
  endtask
  task automatic wait_close();
    n = 0;
    while (close_breaker_one !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    bus(1'b0, 6'h00, 32'h0);
    chk("ctrl", q, 32'h8);
    bus(1'b0, 6'h0c, 32'h0);
    chk("dead_b", q, 32'h78);
    bus(1'b0, 6'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    pulse(3'h1);
    stat("disabled", 3'h0);
    sp = 3 + rnd() % 3;
    bus(1'b1, 6'h04, sp);
    bus(1'b1, 6'h08, 32'h9);
    bus(1'b1, 6'h0c, 32'hf);
    bus(1'b1, 6'h10, 32'h14);
    for (p = 0; p < 4; p++) for (k = 1; k < 5; k <<= 1) begin
      bus(1'b1, 6'h00, 32'h49 | (p << 1));
      stat("armed", 3'h1);
      t = dt(p, k, sp);
      pulse(k);
      if (t == 0) begin
        stat("lockout", 3'h4);
        chk("lock_flag", lockout_flag, 1);
        chk("force", force_three_pole_trip, p > 1);
        pulse(3'h1);
        stat("held", 3'h4);
      end else begin
        stat("in_progress", 3'h2);
        chk("rip_flag", reclose_in_progress_flag, 1);
        if (k != 1) chk("force", force_three_pole_trip, p > 1);
        wait_close();
        chk("dead_time", n > t * 10 - 25 && n < t * 10 + 10, 1);
        repeat (300) @(posedge clock);
        stat("reset", 3'h1);
      end
    end
    // Both breakers together, then a second shot on timer B
    bus(1'b1, 6'h00, 32'h59);
    pulse(3'h1);
    wait_close();
    chk("close_two", close_breaker_two, 1);
    repeat (20) @(posedge clock);
    pulse(3'h1);
    chk("force_shot", force_three_pole_trip, 1);
    wait_close();
    chk("second_b", n > 125 && n < 160, 1);
    repeat (300) @(posedge clock);
    stat("reset_both", 3'h1);
    // Breaker one first, breaker two after the transfer time
    bus(1'b1, 6'h18, 32'h5);
    bus(1'b1, 6'h00, 32'h69);
    pulse(3'h1);
    wait_close();
    chk("seq_two_first", close_breaker_two, 0);
    repeat (300) @(posedge clock);
    stat("seq_reset", 3'h1);
    // Hold freezes the dead time, then timer B runs; then the limit
    bus(1'b1, 6'h00, 32'h41);
    pulse(3'h1);
    hold_input <= 1'b1;
    repeat (100) @(posedge clock);
    hold_input <= 1'b0;
    chk("force_sp", force_three_pole_trip, 1);
    wait_close();
    chk("hold_b", n > 140 && n < 160, 1);
    pulse(3'h1);
    stat("shot_limit", 3'h4);
    chk("limit_flag", lockout_flag, 1);
    // Reset pin releases lockout; a clear ends a cycle at once
    scheme_reset_input <= 1'b1;
    repeat (4) @(posedge clock);
    scheme_reset_input <= 1'b0;
    stat("pin_reset", 3'h1);
    pulse(3'h1);
    sync_clear <= 1'b1;
    @(posedge clock);
    sync_clear <= 1'b0;
    @(posedge clock);
    chk("clear_rip", reclose_in_progress_flag, 0);
    stat("after_clear", 3'h1);
    complete_run();
  end
endmodule
